// file: pic_pkg.sv
// package: register map, field layout, codes and carrier types
// Functional notes
// - two-bit field: 0 masked, 1-3 low-high
// - first register holds timer1 and serial levels
// - second register holds timer2, dma0, dma1
// - third register holds dma2, dma3, both pins
// - software reset leaves registers unchanged
// - control upper byte reads zero always
// - double-ack clear: pin0 single or none
// - double-ack set: ack pin, bits 6-2 and 0 ignored
// - vector bit 0 auto, 1 external
// - trigger bit 0 low level, 1 falling edge
// - nonmaskable pin always edge detected
// - higher level presented before lower
// - ties: ser0,ser1,tim1,tim2,dma0-3,req0,req1
// - accepted level loaded into status mask
// - nonmaskable accepted as level 7
// - edge flag cleared at exception start
// - level request gone high is discarded
// - ack cycle address code 7,6,5
package pic_pkg;
  localparam logic [11:0] ADDR_PRI0 = 12'h000;
  localparam logic [11:0] ADDR_PRI1 = 12'h004;
  localparam logic [11:0] ADDR_PRI2 = 12'h008;
  localparam logic [11:0] ADDR_CTRL = 12'h00c;
  localparam logic [11:0] ADDR_STAT = 12'h010;
  localparam logic [15:0] RESET_REG = 16'h0000;
  localparam logic [15:0] CTRL_MASK = 16'h00ff;
  localparam logic [15:0] CTRL_DACK_MASK = 16'h0083;
  localparam int NUM_SRC = 10;
  // control bit positions
  localparam int BIT_DACK = 7;
  localparam int BIT_NONMASKABLE_VECTOR_MODE = 6;
  localparam int BIT_REQV1 = 5;
  localparam int BIT_REQV0 = 4;
  localparam int BIT_REQTM1 = 1;
  localparam int BIT_REQTM0 = 0;
  // priority field positions (low bit of each pair)
  localparam int POS_SER0 = 0;
  localparam int POS_SER1 = 2;
  localparam int POS_TIM1 = 4;
  localparam int POS_TIM2 = 0;
  localparam int POS_DMA0 = 2;
  localparam int POS_DMA1 = 4;
  localparam int POS_DMA2 = 0;
  localparam int POS_DMA3 = 2;
  localparam int POS_REQ0 = 4;
  localparam int POS_REQ1 = 6;
  localparam logic [2:0] LEVEL_NMI = 3'h7;
  localparam logic [2:0] CODE_NMI = 3'h7;
  localparam logic [2:0] CODE_REQ0 = 3'h6;
  localparam logic [2:0] CODE_REQ1 = 3'h5;
  localparam logic [3:0] SRC_NONE = 4'hf;
  localparam logic [3:0] SRC_NMI = 4'ha;
  typedef enum logic [1:0] {ACK_NONE, ACK_SINGLE, ACK_DOUBLE} pic_ack_t;
  typedef struct packed {
    logic       valid;
    logic [3:0] source;
    logic [2:0] level;
    logic [2:0] code;
    pic_ack_t   ack_mode;
  } pic_req_t;
endpackage

// file: pic_arbiter.sv
// fixed-order level arbiter over the programmable sources
`timescale 1ns/1ns
module pic_arbiter #(
  parameter int N = 10
) (
  input  wire logic [N-1:0]     pend,
  input  wire logic [2*N-1:0]   levels,
  input  wire logic [2:0]       mask,
  output logic                  win_valid,
  output logic [3:0]            win_src,
  output logic [1:0]            win_level
);
  import pic_pkg::*;
  logic [1:0] lv;
  always_comb begin
    win_valid = 1'b0;
    win_src   = SRC_NONE;
    win_level = 2'h0;
    // scan lowest order first so earlier index overrides on ties
    for (int i = N - 1; i >= 0; i--) begin
      lv = levels[2*i +: 2];
      if (pend[i] && lv != 2'h0 && {1'b0, lv} > mask && (!win_valid || lv >= win_level)) begin
        win_valid = 1'b1;
        win_src   = 4'(i);
        win_level = lv;
      end
    end
  end
endmodule

// file: pic_top.sv
// interrupt priority controller with apb registers
`timescale 1ns/1ns
module pic_top (
  input  wire logic                 pclk,
  input  wire logic                 presetn,
  input  wire logic                 psel,
  input  wire logic                 penable,
  input  wire logic                 pwrite,
  input  wire logic [11:0]          paddr,
  input  wire logic [31:0]          pwdata,
  output logic [31:0]               prdata,
  output logic                      pready,
  output logic                      pslverr,
  input  wire logic [7:0]           onchip_req,
  input  wire logic                 nmi_n,
  input  wire logic                 request_pin_zero_n,
  input  wire logic                 request_pin_one_n,
  input  wire logic                 soft_reset,
  input  wire logic                 cpu_accept,
  input  wire logic [2:0]           status_mask_in,
  output pic_pkg::pic_req_t         irq_out,
  output logic [2:0]                status_mask_level,
  output logic                      status_mask_load,
  output logic                      ack_cycle,
  output logic [3:1]                ack_addr,
  output logic                      acknowledge_output_pin_n
);
  import pic_pkg::*;

  logic [15:0] priority_timer1_serial;
  logic [15:0] priority_timer2_dma01;
  logic [15:0] priority_dma23_extreq;
  logic [15:0] external_interrupt_control;
  logic        req0_d;
  logic        req1_d;
  logic        nmi_d;
  logic        req0_edge_flag;
  logic        req1_edge_flag;
  logic        nmi_flag;

  // apb decode
  wire         apb_wr     = psel && penable && pwrite;
  wire         apb_rd     = psel && !penable && !pwrite;
  wire         hit_pri0   = paddr == ADDR_PRI0;
  wire         hit_pri1   = paddr == ADDR_PRI1;
  wire         hit_pri2   = paddr == ADDR_PRI2;
  wire         hit_ctrl   = paddr == ADDR_CTRL;
  wire         hit_stat   = paddr == ADDR_STAT;
  wire         hit_any    = hit_pri0 | hit_pri1 | hit_pri2 | hit_ctrl | hit_stat;

  // effective control with double-ack override
  wire         dack       = external_interrupt_control[BIT_DACK];
  wire [15:0]  ctrl_eff   = dack ? (external_interrupt_control & CTRL_DACK_MASK)
                                 : external_interrupt_control;
  wire         req0_edge_mode = ctrl_eff[BIT_REQTM0] && !dack;
  wire         req1_edge_mode = ctrl_eff[BIT_REQTM1];
  wire         nonmaskable_vector_mode       = ctrl_eff[BIT_NONMASKABLE_VECTOR_MODE];
  wire         reqv0      = ctrl_eff[BIT_REQV0];
  wire         reqv1      = ctrl_eff[BIT_REQV1];

  // external pin detection
  wire         req0_fall  = req0_d && !request_pin_zero_n;
  wire         req1_fall  = req1_d && !request_pin_one_n;
  wire         nmi_fall   = nmi_d && !nmi_n;
  // level mode follows the pin, so a request gone high is dropped
  wire         req0_pend  = req0_edge_mode ? req0_edge_flag : !request_pin_zero_n;
  wire         req1_pend  = req1_edge_mode ? req1_edge_flag : !request_pin_one_n;

  wire [NUM_SRC-1:0] pend = {req1_pend, req0_pend, onchip_req};
  // ordered as ser0, ser1, tim1, tim2, dma0..3, req0, req1
  wire [2*NUM_SRC-1:0] levels = {
    priority_dma23_extreq[POS_REQ1 +: 2], priority_dma23_extreq[POS_REQ0 +: 2],
    priority_dma23_extreq[POS_DMA3 +: 2], priority_dma23_extreq[POS_DMA2 +: 2],
    priority_timer2_dma01[POS_DMA1 +: 2], priority_timer2_dma01[POS_DMA0 +: 2],
    priority_timer2_dma01[POS_TIM2 +: 2], priority_timer1_serial[POS_TIM1 +: 2],
    priority_timer1_serial[POS_SER1 +: 2], priority_timer1_serial[POS_SER0 +: 2]
  };

  logic        win_valid;
  logic [3:0]  win_src;
  logic [1:0]  win_level;

  pic_arbiter #(.N(NUM_SRC)) u_arb (
    .pend      (pend),
    .levels    (levels),
    .mask      (status_mask_in),
    .win_valid (win_valid),
    .win_src   (win_src),
    .win_level (win_level)
  );

  // candidate request, nonmaskable above all
  pic_req_t next_req;
  always_comb begin
    next_req = '0;
    next_req.source = SRC_NONE;
    if (nmi_flag) begin
      next_req.valid    = 1'b1;
      next_req.source   = SRC_NMI;
      next_req.level    = LEVEL_NMI;
      next_req.code     = CODE_NMI;
      next_req.ack_mode = nonmaskable_vector_mode ? ACK_SINGLE : ACK_NONE;
    end else if (win_valid) begin
      next_req.valid  = 1'b1;
      next_req.source = win_src;
      next_req.level  = {1'b0, win_level};
      if (win_src == 4'(NUM_SRC - 2)) begin
        next_req.code     = CODE_REQ0;
        next_req.ack_mode = dack ? ACK_DOUBLE : (reqv0 ? ACK_SINGLE : ACK_NONE);
      end else if (win_src == 4'(NUM_SRC - 1)) begin
        next_req.code     = CODE_REQ1;
        next_req.ack_mode = reqv1 ? ACK_SINGLE : ACK_NONE;
      end
    end
  end

  // accept strobe from the core refers to the presented request
  wire         take       = cpu_accept && irq_out.valid;
  wire         take_req0  = take && irq_out.source == 4'(NUM_SRC - 2);
  wire         take_req1  = take && irq_out.source == 4'(NUM_SRC - 1);
  wire         take_nmi   = take && irq_out.source == SRC_NMI;
  wire         take_ack   = take && irq_out.ack_mode != ACK_NONE;
  wire         take_dack  = take && irq_out.ack_mode == ACK_DOUBLE;

  // registers: hardware reset only, soft_reset ignored
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      priority_timer1_serial     <= RESET_REG;
      priority_timer2_dma01      <= RESET_REG;
      priority_dma23_extreq      <= RESET_REG;
      external_interrupt_control <= RESET_REG;
    end else if (apb_wr) begin
      if (hit_pri0) priority_timer1_serial <= pwdata[15:0];
      if (hit_pri1) priority_timer2_dma01 <= pwdata[15:0];
      if (hit_pri2) priority_dma23_extreq <= pwdata[15:0];
      if (hit_ctrl) external_interrupt_control <= pwdata[15:0] & CTRL_MASK;
    end
  end

  // apb answer: read data loaded in setup, ready in access
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata  <= 32'h0;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready  <= psel && !penable;
      pslverr <= psel && !penable && !hit_any;
      if (apb_rd) begin
        prdata <= 32'h0;
        if (hit_pri0) prdata <= {16'h0, priority_timer1_serial};
        if (hit_pri1) prdata <= {16'h0, priority_timer2_dma01};
        if (hit_pri2) prdata <= {16'h0, priority_dma23_extreq};
        if (hit_ctrl) prdata <= {16'h0, external_interrupt_control & CTRL_MASK};
        if (hit_stat) prdata <= {16'h0, 4'h0, status_mask_level, 1'b0, irq_out.valid,
                                 irq_out.level, irq_out.source};
      end
    end
  end

  // pin history and edge flags; set wins over clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      req0_d         <= 1'b1;
      req1_d         <= 1'b1;
      nmi_d          <= 1'b1;
      req0_edge_flag <= 1'b0;
      req1_edge_flag <= 1'b0;
      nmi_flag       <= 1'b0;
    end else begin
      req0_d <= request_pin_zero_n;
      req1_d <= request_pin_one_n;
      nmi_d  <= nmi_n;
      if (req0_fall && req0_edge_mode) req0_edge_flag <= 1'b1;
      else if (take_req0 || !req0_edge_mode) req0_edge_flag <= 1'b0;
      if (req1_fall && req1_edge_mode) req1_edge_flag <= 1'b1;
      else if (take_req1 || !req1_edge_mode) req1_edge_flag <= 1'b0;
      if (nmi_fall) nmi_flag <= 1'b1;
      else if (take_nmi) nmi_flag <= 1'b0;
    end
  end

  // presented request and acceptance outputs
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_out                  <= '{valid: 1'b0, source: SRC_NONE, level: 3'h0,
                                    code: 3'h0, ack_mode: ACK_NONE};
      status_mask_level        <= 3'h0;
      status_mask_load         <= 1'b0;
      ack_cycle                <= 1'b0;
      ack_addr                 <= 3'h0;
      acknowledge_output_pin_n <= 1'b1;
    end else begin
      irq_out                  <= take ? '{valid: 1'b0, source: SRC_NONE, level: 3'h0,
                                           code: 3'h0, ack_mode: ACK_NONE}
                                       : next_req;
      status_mask_load         <= take;
      if (take) status_mask_level <= irq_out.level;
      ack_cycle                <= take_ack;
      ack_addr                 <= take_ack ? irq_out.code : 3'h0;
      acknowledge_output_pin_n <= !take_dack;
    end
  end
endmodule

// file: pic_core_model.sv
// core model: takes presented requests and keeps the status mask
`timescale 1ns/1ns
module pic_core_model (
  input  wire logic              pclk,
  input  wire logic              presetn,
  input  wire logic              accept_en,
  input  wire logic              mask_clr,
  input  wire pic_pkg::pic_req_t irq_out,
  input  wire logic [2:0]        status_mask_level,
  input  wire logic              status_mask_load,
  output logic                   cpu_accept,
  output logic [2:0]             status_mask_in
);
  import pic_pkg::*;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cpu_accept <= 1'b0;
      status_mask_in <= 3'h0;
    end else begin
      cpu_accept <= accept_en && irq_out.valid && !cpu_accept;
      if (status_mask_load) begin
        status_mask_in <= status_mask_level;
      end else if (mask_clr) begin
        status_mask_in <= 3'h0;
      end
    end
  end
endmodule

// file: pic_chk.sv
// port checker for the interrupt controller
`timescale 1ns/1ns
module pic_chk (
  input wire logic              pclk,
  input wire logic              presetn,
  input wire logic              psel,
  input wire logic              penable,
  input wire logic              pready,
  input wire logic              pslverr,
  input wire logic              cpu_accept,
  input wire logic [2:0]        status_mask_in,
  input wire pic_pkg::pic_req_t irq_out,
  input wire logic [2:0]        status_mask_level,
  input wire logic              status_mask_load,
  input wire logic              ack_cycle,
  input wire logic [3:1]        ack_addr,
  input wire logic              acknowledge_output_pin_n
);
  import pic_pkg::*;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_take;
    cpu_accept && irq_out.valid;
  endsequence
  a_zero_wait: assert property ((psel && !penable) ##1 (psel && penable) |-> pready)
    else $error("pready missing in access");
  a_err_pair: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  a_mask_load: assert property (s_take |=> status_mask_load &&
    status_mask_level == $past(irq_out.level)) else $error("mask not loaded");
  a_take_drop: assert property (s_take |=> !irq_out.valid)
    else $error("request kept after accept");
  a_nmi_seven: assert property (irq_out.valid && irq_out.source == SRC_NMI
    |-> irq_out.level == LEVEL_NMI) else $error("nmi level wrong");
  a_above_mask: assert property (irq_out.valid && irq_out.source != SRC_NMI
    |-> irq_out.level != 3'h0 && irq_out.level > $past(status_mask_in))
    else $error("request not above mask");
  a_ack_code: assert property (s_take ##0 irq_out.ack_mode != ACK_NONE
    |=> ack_cycle && ack_addr == $past(irq_out.code)) else $error("ack code wrong");
  a_dack_pin: assert property (s_take ##0 irq_out.ack_mode == ACK_DOUBLE
    |=> !acknowledge_output_pin_n ##1 acknowledge_output_pin_n) else $error("ack pin wrong");
  a_req_code: assert property (irq_out.valid && irq_out.source == 4'h8
    |-> irq_out.code == CODE_REQ0) else $error("pin zero code wrong");
endmodule
bind pic_top pic_chk u_chk (.pclk, .presetn, .psel, .penable, .pready, .pslverr, .cpu_accept,
  .status_mask_in, .irq_out, .status_mask_level, .status_mask_load, .ack_cycle, .ack_addr,
  .acknowledge_output_pin_n);

// file: pic_top_bench.sv
// self-checking bench for the interrupt controller
`timescale 1ns/1ns
module pic_top_bench;
  import pic_pkg::*;
  logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic        nmi_n = 1'b1, rq0_n = 1'b1, soft_reset = 1'b0, accept_en = 1'b0, mask_clr = 1'b0;
  logic        rq1_n = 1'b1;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic [7:0]  onchip_req = 8'h00;
  logic        pready, pslverr, cpu_accept, status_mask_load, ack_cycle, ack_pin_n, err;
  logic [2:0]  status_mask_in, status_mask_level;
  logic [3:1]  ack_addr;
  pic_req_t    irq_out;
  int          failures = 0, cmp_count = 0;
  always #25 pclk = ~pclk;
  pic_top DUT (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .onchip_req, .nmi_n, .request_pin_zero_n(rq0_n), .request_pin_one_n(rq1_n),
    .soft_reset, .cpu_accept, .status_mask_in, .irq_out, .status_mask_level,
    .status_mask_load, .ack_cycle, .ack_addr, .acknowledge_output_pin_n(ack_pin_n));
  pic_core_model u_core (.pclk, .presetn, .accept_en, .mask_clr, .irq_out,
    .status_mask_level, .status_mask_load, .cpu_accept, .status_mask_in);
  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      failures++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wait_load;
    do begin
      @(posedge pclk);
    end while (status_mask_load !== 1'b1);
  endtask
  task automatic t_regs;
    for (int i = 0; i < 4; i++) begin
      apb(1'b0, 12'(4 * i), 32'h0);
      check("reset", rd, 32'h0);
    end
    apb(1'b1, ADDR_PRI0, 32'h0037);
    apb(1'b1, ADDR_CTRL, 32'hff73);
    apb(1'b0, ADDR_CTRL, 32'h0);
    check("ctrl", rd, 32'h0073);
    apb(1'b0, 12'h020, 32'h0);
    check("unmapped", {31'h0, err}, 32'h1);
    @(posedge pclk);
    soft_reset <= 1'b1;
    @(posedge pclk);
    soft_reset <= 1'b0;
    apb(1'b0, ADDR_PRI0, 32'h0);
    check("pri0", rd, 32'h0037);
    apb(1'b1, ADDR_CTRL, 32'h0);
    $display("regs test done");
  endtask
  task automatic t_prio;
    apb(1'b1, ADDR_PRI0, 32'h0035);
    onchip_req <= 8'h07;
    repeat (3) @(posedge pclk);
    check("hi src", {irq_out.source, 1'b0, irq_out.level}, 8'h23);
    onchip_req <= 8'h03;
    repeat (3) @(posedge pclk);
    check("tie src", {irq_out.source, 1'b0, irq_out.level}, 8'h01);
    apb(1'b1, ADDR_PRI0, 32'h0034);
    onchip_req <= 8'h01;
    repeat (3) @(posedge pclk);
    check("masked", irq_out.valid, 1'b0);
    apb(1'b1, ADDR_PRI1, 32'h000c);
    onchip_req <= 8'h10;
    repeat (3) @(posedge pclk);
    check("dma0", {irq_out.source, 1'b0, irq_out.level}, 8'h43);
    onchip_req <= 8'h00;
    $display("priority test done");
  endtask
  task automatic t_edge;
    apb(1'b1, ADDR_PRI2, 32'h0020);
    apb(1'b1, ADDR_CTRL, 32'h0011);
    rq0_n <= 1'b0;
    repeat (2) @(posedge pclk);
    rq0_n <= 1'b1;
    repeat (3) @(posedge pclk);
    check("edge req", {irq_out.valid, irq_out.source, irq_out.code}, 8'hc6);
    accept_en <= 1'b1;
    wait_load;
    check("mask", status_mask_level, 3'h2);
    check("ack", {ack_cycle, ack_addr}, 4'he);
    accept_en <= 1'b0;
    mask_clr <= 1'b1;
    repeat (3) @(posedge pclk);
    mask_clr <= 1'b0;
    check("flag clr", irq_out.valid, 1'b0);
    apb(1'b1, ADDR_CTRL, 32'h0010);
    rq0_n <= 1'b0;
    repeat (3) @(posedge pclk);
    check("level on", irq_out.valid, 1'b1);
    rq0_n <= 1'b1;
    repeat (3) @(posedge pclk);
    check("level off", irq_out.valid, 1'b0);
    apb(1'b1, ADDR_PRI2, 32'h00a0);
    apb(1'b1, ADDR_CTRL, 32'h0022);
    rq0_n <= 1'b0;
    rq1_n <= 1'b0;
    repeat (2) @(posedge pclk);
    rq1_n <= 1'b1;
    repeat (3) @(posedge pclk);
    check("pin tie", irq_out.source, 4'h8);
    rq0_n <= 1'b1;
    repeat (3) @(posedge pclk);
    check("req1 edge", {irq_out.valid, irq_out.source, irq_out.code}, 8'hcd);
    accept_en <= 1'b1;
    wait_load;
    accept_en <= 1'b0;
    check("req1 ack", {ack_cycle, ack_addr}, 4'hd);
    mask_clr <= 1'b1;
    repeat (2) @(posedge pclk);
    mask_clr <= 1'b0;
    $display("pin test done");
  endtask
  task automatic t_dack;
    apb(1'b1, ADDR_CTRL, 32'h0081);
    rq0_n <= 1'b0;
    repeat (3) @(posedge pclk);
    check("dack mode", irq_out.ack_mode, ACK_DOUBLE);
    accept_en <= 1'b1;
    wait_load;
    accept_en <= 1'b0;
    check("ack pin", ack_pin_n, 1'b0);
    rq0_n <= 1'b1;
    nmi_n <= 1'b0;
    repeat (3) @(posedge pclk);
    nmi_n <= 1'b1;
    check("nmi", {irq_out.source, 1'b0, irq_out.level}, 8'ha7);
    accept_en <= 1'b1;
    wait_load;
    accept_en <= 1'b0;
    check("nmi mask", status_mask_level, LEVEL_NMI);
    apb(1'b0, ADDR_STAT, 32'h0);
    check("status", rd, 32'h00000e0f);
    $display("double ack test done");
  endtask
  task automatic complete_run;
    $display("compares %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  initial begin
    #200000;
    failures++;
    complete_run;
  end
  initial begin
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    t_regs;
    t_prio;
    t_edge;
    t_dack;
    complete_run;
  end
endmodule
